// ==== dot_matrix_lcd_drive_control.sv ====
// Notes on behaviour
// - 48x8 option turns commons 8-16 into segments
// - Commons 16..9 give segments 40..47, 8 gives 47
// - Power bit enables the drive-voltage generator
// - All-on bit lights every segment
// - All-off bit blanks segments unless all-on
// - No forcing: segments follow display memory
// - All-on wins over all-off
// - Duty field: 1x eighth, 01 sixteenth, 00 seventeenth
// - Frame 32 Hz, or 30.12 Hz at seventeenth
// - Memory bit one lights dot, zero blanks
// - Sixteenth/seventeenth duty output all used commons
// - Eighth duty: commons 0-7, page bit picks bank
// - Display memory F000-F25E is read/write
// - Unused display locations are plain storage
// - Display memory is not cleared at reset
// - Four-bit contrast code, light to dark
// - Reset clears control bits; 48x8 resets eighth duty
// - Forcing never alters display memory
//
// Local design decisions: the register addresses and the Wishbone register port.
module dot_matrix_lcd_drive_control
    import lcd_drive_pkg::*;
#(
    parameter bit MASK_48X8 = 1'b0
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [17:2] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        stb_i,
    input  wire logic        cyc_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        low_speed_oscillator_i,
    output logic      [16:0] common_lines_o,
    output logic      [39:0] segment_lines_o,
    output logic             drive_power_on_o,
    output logic      [3:0]  contrast_code_o
);

    drive_ctrl_t       drive_ctrl;
    display_ctrl_t     display_ctrl;
    logic              busy;
    logic              wr_lane;
    logic              cpu_hit;
    logic [MEM_AW-1:0] cpu_addr;
    logic              cpu_we;
    logic [MEM_DW-1:0] cpu_rdata;
    logic [31:0]       next_dat;

    logic [2:0]        osc_sync;
    logic              osc_level;
    logic              osc_tick;
    logic [6:0]        slot_cnt;
    logic [6:0]        slot_last;
    logic              slot_end;
    logic              duty8;
    logic              duty16;
    logic [4:0]        com_last;
    logic [5:0]        seg_last;
    logic [4:0]        com_idx;
    logic [4:0]        fetch_com;
    logic [5:0]        fetch_seg;
    logic [5:0]        rd_seg;
    logic              rd_valid;
    logic [MEM_AW-1:0] scan_addr;
    logic [MEM_DW-1:0] scan_rdata;
    scan_state_t       state;
    logic [47:0]       shadow;
    logic [47:0]       seg_disp;
    logic [16:0]       com_sel;
    logic [47:0]       next_seg;
    logic [16:0]       next_common;

    function automatic logic mem_hit(input logic [15:0] idx);
        logic ok;
        ok = 1'b0;
        if (idx[15:10] == MEM_IDX_TOP)
        begin
            case (idx[9:8])
                BANK_LOW, BANK_MID: ok = idx[7:0] < MEM_BANK_SIZE;
                BANK_HIGH:          ok = (idx[7:0] < MEM_BANK_SIZE) && !idx[0];
                default:            ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : mem_hit

    function automatic logic [MEM_AW-1:0] scan_address(
        input logic       eighth,
        input logic       page,
        input logic [4:0] com,
        input logic [5:0] seg
    );
        logic [1:0] bank;
        logic [6:0] off;
        off  = {seg, 1'b0};
        bank = BANK_HIGH;
        if (!com[4])
        begin
            off[0] = com[2];
            bank   = eighth ? {1'b0, page} : {1'b0, com[3]};
        end
        return {bank, off};
    endfunction : scan_address

    // Each access takes two edges: one to read the memory port, one to
    // register the answer, so dat_o can come straight from a flop.
    assign wr_lane  = busy && we_i && sel_i[0];
    assign cpu_hit  = mem_hit(adr_i);
    // The port counts from bit 2, so index bit n sits at adr_i[n + 2].
    assign cpu_addr = {adr_i[11:10], adr_i[8:2]};
    assign cpu_we   = wr_lane && cpu_hit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy  <= 1'b0;
            ack_o <= 1'b0;
        end
        else
        begin
            busy  <= cyc_i && stb_i && !ack_o && !busy;
            ack_o <= busy;
        end
    end

    always_comb
    begin
        next_dat = 32'h0000_0000;
        if (cpu_hit)
        begin
            next_dat[3:0] = cpu_rdata;
        end
        else if (adr_i == IDX_DRIVE_CTRL)
        begin
            next_dat[3:0] = drive_ctrl;
        end
        else if (adr_i == IDX_DISPLAY_CTRL)
        begin
            next_dat[3:0] = display_ctrl;
        end
        else if (adr_i == IDX_CONTRAST)
        begin
            next_dat[3:0] = contrast_code_o;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (busy)
        begin
            dat_o <= next_dat;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_ctrl <= MASK_48X8 ? DRIVE_CTRL_RESET_48X8
                                    : DRIVE_CTRL_RESET;
        end
        else if (wr_lane && adr_i == IDX_DRIVE_CTRL)
        begin
            drive_ctrl <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            display_ctrl <= DISPLAY_CTRL_RESET;
        end
        else if (wr_lane && adr_i == IDX_DISPLAY_CTRL)
        begin
            display_ctrl <= dat_i[3:0];
        end
    end

    // The contrast code is deliberately left out of reset.
    always_ff @(posedge clk_i)
    begin
        if (wr_lane && adr_i == IDX_CONTRAST)
        begin
            contrast_code_o <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_power_on_o <= 1'b0;
        end
        else
        begin
            drive_power_on_o <= drive_ctrl.drive_power_on;
        end
    end

    lcd_display_ram u_ram (
        .clk_i        (clk_i),
        .cpu_addr_i   (cpu_addr),
        .cpu_we_i     (cpu_we),
        .cpu_wdata_i  (dat_i[3:0]),
        .cpu_rdata_o  (cpu_rdata),
        .scan_addr_i  (scan_addr),
        .scan_rdata_o (scan_rdata)
    );

    // Under the 48x8 option only eighth duty exists, whatever is written.
    assign duty8     = drive_ctrl.duty_select_hi || MASK_48X8;
    assign duty16    = !duty8 && drive_ctrl.duty_select_lo;
    assign com_last  = duty8 ? COM_LAST_8
                             : (duty16 ? COM_LAST_16 : COM_LAST_17);
    assign seg_last  = MASK_48X8 ? SEG_LAST_48X8 : SEG_LAST_STD;
    // Eighth duty stretches each slot so the frame stays at 32 Hz.
    assign slot_last = duty8 ? SLOT_LAST_8 : SLOT_LAST_16;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_sync  <= 3'h0;
            osc_level <= 1'b0;
        end
        else
        begin
            osc_sync <= {osc_sync[1:0], low_speed_oscillator_i};
            if (osc_sync[1] == osc_sync[2])
            begin
                osc_level <= osc_sync[2];
            end
        end
    end

    assign osc_tick = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_level;
    // A duty change can leave the count past the new end; >= recovers.
    assign slot_end = osc_tick && (slot_cnt >= slot_last);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slot_cnt <= 7'h00;
            com_idx  <= 5'h00;
        end
        else if (slot_end)
        begin
            slot_cnt <= 7'h00;
            com_idx  <= (com_idx >= com_last) ? 5'h00 : com_idx + 5'h01;
        end
        else if (osc_tick)
        begin
            slot_cnt <= slot_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state     <= SCAN_IDLE;
            fetch_com <= 5'h00;
            fetch_seg <= 6'h00;
        end
        else
        begin
            case (state)
                SCAN_IDLE:
                begin
                    if (slot_end)
                    begin
                        state     <= SCAN_FETCH;
                        fetch_com <= (com_idx >= com_last) ? 5'h00
                                                           : com_idx + 5'h01;
                        fetch_seg <= 6'h00;
                    end
                end
                SCAN_FETCH:
                begin
                    fetch_seg <= fetch_seg + 6'h01;
                    if (fetch_seg == seg_last)
                    begin
                        state <= SCAN_DRAIN;
                    end
                end
                SCAN_DRAIN: state <= SCAN_LATCH;
                SCAN_LATCH: state <= SCAN_IDLE;
                default:    state <= SCAN_IDLE;
            endcase
        end
    end

    assign scan_addr = scan_address(duty8, display_ctrl.display_page_select,
                                    fetch_com, fetch_seg);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_valid <= 1'b0;
            rd_seg   <= 6'h00;
        end
        else
        begin
            rd_valid <= state == SCAN_FETCH;
            rd_seg   <= fetch_seg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shadow <= 48'h0000_0000_0000;
        end
        else if (rd_valid)
        begin
            shadow[rd_seg] <= scan_rdata[fetch_com[1:0]];
        end
    end

    // Segments and common change together so no slot shows stale data.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seg_disp <= 48'h0000_0000_0000;
            com_sel  <= 17'h00000;
        end
        else if (state == SCAN_LATCH)
        begin
            seg_disp <= shadow;
            com_sel  <= 17'(1) << fetch_com;
        end
    end

    // Forcing acts on the outputs only and takes effect at once.
    always_comb
    begin
        next_seg = seg_disp;
        if (display_ctrl.force_all_dots_on)
        begin
            next_seg = {48{1'b1}};
        end
        else if (display_ctrl.force_all_dots_off)
        begin
            next_seg = {48{1'b0}};
        end
    end

    always_comb
    begin
        next_common = com_sel;
        if (MASK_48X8)
        begin
            for (int k = 0; k < 8; k++)
            begin
                next_common[16 - k] = next_seg[40 + k];
            end
            next_common[8] = next_seg[47];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            segment_lines_o <= 40'h00_0000_0000;
            common_lines_o  <= 17'h00000;
        end
        else
        begin
            segment_lines_o <= next_seg[39:0];
            common_lines_o  <= next_common;
        end
    end

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    force_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        display_ctrl.force_all_dots_on |=> (&segment_lines_o))
        else $error("all-on did not light every segment");

    on_priority_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (display_ctrl.force_all_dots_on && display_ctrl.force_all_dots_off)
        |=> (&segment_lines_o))
        else $error("all-off overrode all-on");

    force_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!display_ctrl.force_all_dots_on && display_ctrl.force_all_dots_off)
        |=> (segment_lines_o == 40'h00_0000_0000))
        else $error("all-off did not blank segments");

    normal_display_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!display_ctrl.force_all_dots_on && !display_ctrl.force_all_dots_off)
        |=> (segment_lines_o === $past(seg_disp[39:0])))
        else $error("segments do not follow display memory");

    power_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane && adr_i == IDX_DRIVE_CTRL)
        |=> ##1 (drive_power_on_o == $past(dat_i[0], 2)))
        else $error("power output does not follow written bit");

    eighth_commons_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!MASK_48X8 && state == SCAN_LATCH && duty8)
        |=> ##1 ($onehot(common_lines_o) && common_lines_o[16:8] == 9'h000))
        else $error("eighth duty drove a common above 7");

    slot_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (slot_end && duty8) |-> (slot_cnt == SLOT_LAST_8))
        else $error("eighth-duty slot length wrong");

    page_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == SCAN_FETCH && duty8)
        |-> (scan_addr[8:7] == {1'b0, display_ctrl.display_page_select}))
        else $error("scan read from the wrong page");

    reset_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (display_ctrl == DISPLAY_CTRL_RESET
        && drive_ctrl == (MASK_48X8 ? DRIVE_CTRL_RESET_48X8 : DRIVE_CTRL_RESET)))
        else $error("control bits not at reset values");

    mask_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
        MASK_48X8 |-> (common_lines_o[8] === common_lines_o[9]))
        else $error("common 8 and 9 differ under 48x8 option");

endmodule : dot_matrix_lcd_drive_control

// ==== lcd_display_ram.sv ====
module lcd_display_ram
    import lcd_drive_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [MEM_AW-1:0] cpu_addr_i,
    input  wire logic              cpu_we_i,
    input  wire logic [MEM_DW-1:0] cpu_wdata_i,
    output logic      [MEM_DW-1:0] cpu_rdata_o,
    input  wire logic [MEM_AW-1:0] scan_addr_i,
    output logic      [MEM_DW-1:0] scan_rdata_o
);

    // Contents are never cleared; software must load them after reset.
    logic [MEM_DW-1:0] store [0:(1 << MEM_AW) - 1];

    always_ff @(posedge clk_i)
    begin
        if (cpu_we_i)
        begin
            store[cpu_addr_i] <= cpu_wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        cpu_rdata_o <= store[cpu_addr_i];
    end

    always_ff @(posedge clk_i)
    begin
        scan_rdata_o <= store[scan_addr_i];
    end

endmodule : lcd_display_ram

// ==== lcd_drive_pkg.sv ====
package lcd_drive_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_DRIVE_CTRL   = 16'hff60;
    localparam logic [15:0] IDX_DISPLAY_CTRL = 16'hff61;
    localparam logic [15:0] IDX_CONTRAST     = 16'hff62;

    // Display memory window F000-F3FF, three banks of 0x60 nibbles; the top bank takes even ones only.
    localparam logic [5:0]  MEM_IDX_TOP      = 6'h3c;
    localparam logic [7:0]  MEM_BANK_SIZE    = 8'h60;
    localparam logic [1:0]  BANK_LOW         = 2'h0;
    localparam logic [1:0]  BANK_MID         = 2'h1;
    localparam logic [1:0]  BANK_HIGH        = 2'h2;
    localparam int          MEM_AW           = 9;
    localparam int          MEM_DW           = 4;

    // Field layouts follow bit order D3..D0.
    typedef struct packed {
        logic duty_select_hi;
        logic duty_select_lo;
        logic spare;
        logic drive_power_on;
    } drive_ctrl_t;

    typedef struct packed {
        logic expansion;
        logic force_all_dots_off;
        logic force_all_dots_on;
        logic display_page_select;
    } display_ctrl_t;

    localparam logic [3:0]  DRIVE_CTRL_RESET      = 4'h0;
    localparam logic [3:0]  DRIVE_CTRL_RESET_48X8 = 4'h8;
    localparam logic [3:0]  DISPLAY_CTRL_RESET    = 4'h0;

    // Frame timing from the 32.768 kHz oscillator.
    localparam int          CLK_HZ           = 20_000_000;
    localparam int          OSC_HZ           = 32_768;
    localparam int          FRAME_HZ         = 32;
    localparam logic [6:0]  SLOT_LAST_8      = 7'(OSC_HZ / (FRAME_HZ * 8) - 1);
    localparam logic [6:0]  SLOT_LAST_16     = 7'(OSC_HZ / (FRAME_HZ * 16) - 1);

    localparam logic [4:0]  COM_LAST_8       = 5'h07;
    localparam logic [4:0]  COM_LAST_16      = 5'h0f;
    localparam logic [4:0]  COM_LAST_17      = 5'h10;
    localparam logic [5:0]  SEG_LAST_STD     = 6'h27;
    localparam logic [5:0]  SEG_LAST_48X8    = 6'h2f;

    typedef enum logic [1:0] {
        SCAN_IDLE  = 2'b00,
        SCAN_FETCH = 2'b01,
        SCAN_DRAIN = 2'b10,
        SCAN_LATCH = 2'b11
    } scan_state_t;

endpackage : lcd_drive_pkg

// ==== lcd_panel_model.sv ====
module lcd_panel_model
(
    input  wire logic        clk_i,
    input  wire logic        clear_i,
    input  wire logic [16:0] common_lines_i,
    input  wire logic [39:0] segment_lines_i,
    input  wire logic        drive_power_on_i,
    output logic      [4:0]  max_com_o,
    output logic      [15:0] slot_len_o
);
    logic [16:0] prev_com;
    logic [15:0] cnt;
    logic [4:0]  idx;

    // The panel only sees which common is selected; this decode keeps no state.
    always_comb
    begin
        idx = 5'h00;
        for (int i = 0; i < 17; i++)
            if (common_lines_i[i])
                idx = 5'(i);
    end

    // Slot length is the clock count between two changes of common.
    always_ff @(posedge clk_i)
    begin
        prev_com <= common_lines_i;
        if (common_lines_i != prev_com)
        begin
            slot_len_o <= cnt;
            cnt        <= 16'h0001;
        end
        else
            cnt <= cnt + 16'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (clear_i)
            max_com_o <= 5'h00;
        else if (idx > max_com_o)
            max_com_o <= idx;
    end
endmodule : lcd_panel_model

// ==== tb_dot_matrix_lcd_drive_control.sv ====
module tb_dot_matrix_lcd_drive_control;
    timeunit 1ns;
    timeprecision 1ns;
    import lcd_drive_pkg::*;

    localparam int OSC_HALF = 4;
    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    logic [15:0] adr          = 16'h0000;
    logic [31:0] dat_w        = 32'h0000_0000;
    logic        we           = 1'b0;
    logic [3:0]  sel          = 4'h0;
    logic        stb          = 1'b0;
    logic        cyc          = 1'b0;
    logic        osc          = 1'b0;
    logic        clr          = 1'b0;
    logic [31:0] dat_r;
    logic        ack;
    logic [16:0] com;
    logic [39:0] seg;
    logic        pwr;
    logic [3:0]  contrast;
    logic [4:0]  max_com;
    logic [15:0] slot_len;
    logic [3:0]  rd;
    logic [31:0] dat_m;
    logic [16:0] com_m;
    int          n_fail       = 0;
    int          total_checks = 0;

    always #25 clk_i = ~clk_i;

    always
    begin
        repeat (OSC_HALF) @(posedge clk_i);
        osc <= ~osc;
    end

    dot_matrix_lcd_drive_control uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
        .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc),
        .dat_o(dat_r), .ack_o(ack), .low_speed_oscillator_i(osc),
        .common_lines_o(com), .segment_lines_o(seg),
        .drive_power_on_o(pwr), .contrast_code_o(contrast)
    );

    // A second copy built with the 48x8 option shares the bus and clock.
    dot_matrix_lcd_drive_control #(.MASK_48X8(1'b1)) uut_mask
    (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
        .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc),
        .dat_o(dat_m), .ack_o(), .low_speed_oscillator_i(osc),
        .common_lines_o(com_m), .segment_lines_o(),
        .drive_power_on_o(), .contrast_code_o()
    );

    lcd_panel_model panel
    (
        .clk_i(clk_i), .clear_i(clr), .common_lines_i(com),
        .segment_lines_i(seg), .drive_power_on_i(pwr),
        .max_com_o(max_com), .slot_len_o(slot_len)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk_nib(input logic [3:0] act, input logic [3:0] exp);
        total_checks++;
        if (act !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : chk_nib

    task automatic chk_vec(input logic [39:0] act, input logic [39:0] exp);
        total_checks++;
        if (act !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : chk_vec

    // Request is held until ack is sampled high, then released at that edge.
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'h1;
        dat_w <= {28'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_r[3:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
            chk_nib(4'h0, 4'hf);
    endtask : wb

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
        wb(1'b0, a, 4'h0);
        chk_nib(rd, exp);
    endtask : rd_chk

    task automatic wait_com(input int c);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (com !== (17'h1 << c) && n < 20000);
        if (n >= 20000)
            chk_vec(40'(com), 40'(17'h1 << c));
    endtask : wait_com

    task automatic seg0(input logic exp);
        chk_vec({39'h0, seg[0]}, {39'h0, exp});
    endtask : seg0

    // One frame from common 1 round to common 0 gives the top common used.
    task automatic span(input int last, input int slot);
        wait_com(1);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wait_com(0);
        chk_vec(40'(max_com), 40'(last));
        chk_vec(40'(slot_len), 40'(slot));
    endtask : span

    task automatic t_reset();
        rd_chk(IDX_DRIVE_CTRL, DRIVE_CTRL_RESET);
        chk_nib(dat_m[3:0], DRIVE_CTRL_RESET_48X8);
        rd_chk(IDX_DISPLAY_CTRL, DISPLAY_CTRL_RESET);
        chk_nib({3'h0, pwr}, 4'h0);
    endtask : t_reset

    task automatic t_regs();
        wr(IDX_CONTRAST, 4'h7);
        rd_chk(IDX_CONTRAST, 4'h7);
        chk_nib(contrast, 4'h7);
        wr(IDX_CONTRAST, 4'hf);
        chk_nib(contrast, 4'hf);
        wr(IDX_DRIVE_CTRL, 4'h1);
        repeat (3) @(posedge clk_i);
        chk_nib({3'h0, pwr}, 4'h1);
        wr(16'hf05f, 4'ha);
        wr(16'hf25e, 4'h5);
        rd_chk(16'hf05f, 4'ha);
        rd_chk(16'hf25e, 4'h5);
        rd_chk(16'h0010, 4'h0);
    endtask : t_regs

    task automatic t_scan8();
        wr(IDX_DRIVE_CTRL, 4'h8);
        repeat (3) @(posedge clk_i);
        chk_nib({3'h0, pwr}, 4'h0);
        wr(16'hf000, 4'h1);
        wr(16'hf001, 4'h2);
        wr(16'hf002, 4'h0);
        wr(16'hf100, 4'h0);
        wait_com(0);
        seg0(1'b1);
        chk_vec({39'h0, seg[1]}, 40'h0);
        wait_com(5);
        seg0(1'b1);
        // The 48x8 copy fetches eight more segments, so it lags slightly.
        repeat (10) @(posedge clk_i);
        chk_vec(40'(com_m[7:0]), 40'h20);
        chk_vec(40'(com_m[9:8]), 40'h3);
        span(7, 2 * OSC_HALF * 128);
        wr(IDX_DISPLAY_CTRL, 4'h1);
        wait_com(1);
        wait_com(0);
        seg0(1'b0);
        wr(IDX_DISPLAY_CTRL, 4'h0);
    endtask : t_scan8

    task automatic t_force();
        wr(IDX_DISPLAY_CTRL, 4'h2);
        repeat (3) @(posedge clk_i);
        chk_vec(seg, {40{1'b1}});
        wr(IDX_DISPLAY_CTRL, 4'h6);
        repeat (3) @(posedge clk_i);
        chk_vec(seg, {40{1'b1}});
        wr(IDX_DISPLAY_CTRL, 4'h4);
        repeat (3) @(posedge clk_i);
        chk_vec(seg, 40'h0);
        wr(IDX_DISPLAY_CTRL, 4'h0);
        rd_chk(16'hf000, 4'h1);
        wait_com(1);
        wait_com(0);
        seg0(1'b1);
    endtask : t_force

    task automatic t_duty();
        wr(16'hf200, 4'h1);
        wr(IDX_DRIVE_CTRL, 4'h4);
        span(15, 2 * OSC_HALF * 64);
        wr(IDX_DRIVE_CTRL, 4'h0);
        wait_com(16);
        seg0(1'b1);
        span(16, 2 * OSC_HALF * 64);
    endtask : t_duty

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_scan8();
        t_force();
        t_duty();
        tally_and_finish();
    end

    // The scenarios need about eight frames; the limit leaves ample margin.
    initial
    begin
        repeat (90000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_dot_matrix_lcd_drive_control
